// >>> pciu_regs.vh
// Register map, field positions and reset values of the pin change interrupt unit
// Overview of operation
// - Group 0 requests on any unmasked low-source change when enabled and global bit set.
// - Group 0 request leaves on its own vector output, apart from other groups.
// - Flag bit 2 sets on a triggering change of sources 15 to 22.
// - Flag bit 1 sets on a triggering change of sources 8 to 14.
// - Flag bit 0 sets on a triggering change of sources 0 to 7.
// - Set flag plus group enable plus global bit drives that group's vector request.
// - A group flag clears when its handler starts executing.
// - Writing one to a flag bit clears it; writing zero leaves it.
// - Flag register bits 7 to 3 always read as zero.
// - Group 2 mask bits gate sources 15 to 22, only with group 2 enabled.
// - A cleared mask bit makes changes on its pin ignored.
// - Group 1 mask bits 6 to 0 gate sources 8 to 14 with group 1 enabled.
// - Group 1 mask bit 7 is unused and reads as zero.
// - Group 0 mask bits gate sources 0 to 7, only with group 0 enabled.
// - Groups 2 and 1 interrupt through their own vectors when enabled with global bit.
// - Group enables sit in control bits 2 to 0, upper bits zero, reset zero.
`ifndef PCIU_REGS_VH
`define PCIU_REGS_VH
`define PCIU_OFS_CTRL 8'h68
`define PCIU_OFS_FLAG 8'h69
`define PCIU_OFS_MASK0 8'h6B
`define PCIU_OFS_MASK1 8'h6C
`define PCIU_OFS_MASK2 8'h6D
`define PCIU_OFS_IRQ_STAT 8'h70
`define PCIU_OFS_IRQ_MASK 8'h71
`define PCIU_CTRL_BITS 3
`define PCIU_MASK1_BITS 7
`define PCIU_RST_BYTE 8'h00
`define PCIU_RST_GRP 3'h0
`endif

// >>> pciu_top.v
// Pin change interrupt unit with APB register access
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "pciu_regs.vh"
module pciu_top #(
  parameter ADDR_W = 12
) (
  input wire SYS_CLK_I,
  input wire RST_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [ADDR_W-1:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire [3:0] PSTRB_I,
  output reg [31:0] PRDATA_O,
  output wire PREADY_O,
  output wire PSLVERR_O,
  input wire [7:0] CHANGE_SOURCES_LOW_I,
  input wire [6:0] CHANGE_SOURCES_MID_I,
  input wire [7:0] CHANGE_SOURCES_HIGH_I,
  input wire CPU_GLOBAL_IRQ_EN_I,
  input wire [2:0] HANDLER_ENTRY_I,
  output wire [2:0] GROUP_VECTOR_REQ_O,
  output wire IRQ_O
);

  // Group widths; the middle group is one pin short
  localparam integer LOW_W = 8;
  localparam integer MID_W = 7;
  localparam integer HIGH_W = 8;
  localparam integer PIN_W = LOW_W + MID_W + HIGH_W;
  localparam integer GRP_N = `PCIU_CTRL_BITS;
  localparam integer MID_LO = LOW_W;
  localparam integer HIGH_LO = LOW_W + MID_W;
  // Registers sit at word addresses: the byte address is four times the index
  localparam integer IDX_W = 8;

  wire [PIN_W-1:0] pins_in;
  wire [PIN_W-1:0] change;
  wire [PIN_W-1:0] pin_mask;
  wire [PIN_W-1:0] hit;
  wire [GRP_N-1:0] grp_hit;
  wire [GRP_N-1:0] change_flag_bank;
  wire [GRP_N-1:0] irq_stat;
  wire [GRP_N-1:0] flag_wr_clear;
  wire [GRP_N-1:0] flag_hw_clear;
  wire [GRP_N-1:0] stat_rd_clear;

  reg [2:0] group_enable_control;
  reg [7:0] group0_pin_mask;
  reg [6:0] group1_pin_mask;
  reg [7:0] group2_pin_mask;
  reg [2:0] irq_mask;
  reg [31:0] next_rdata;

  wire acc;
  wire wr;
  wire rd;
  wire setup_rd;
  wire [IDX_W-1:0] idx;
  wire upper_zero;
  wire aligned;
  wire in_map;
  reg at_ctrl;
  reg at_flag;
  reg at_m0;
  reg at_m1;
  reg at_m2;
  reg at_ist;
  reg at_imk;
  wire mapped;
  wire wr_ctrl;
  wire wr_flag;
  wire wr_m0;
  wire wr_m1;
  wire wr_m2;
  wire wr_imk;
  wire rd_ist;

  wire [31:0] img_ctrl;
  wire [31:0] img_flag;
  wire [31:0] img_m0;
  wire [31:0] img_m1;
  wire [31:0] img_m2;
  wire [31:0] img_ist;
  wire [31:0] img_imk;

  // Sources in one vector, group 0 in the low bits
  assign pins_in = {CHANGE_SOURCES_HIGH_I, CHANGE_SOURCES_MID_I, CHANGE_SOURCES_LOW_I};

  // APB phase decode; writes use byte lane 0 only
  assign acc = PSEL_I & PENABLE_I;
  assign wr = acc & PWRITE_I & PSTRB_I[0];
  assign rd = acc & ~PWRITE_I;
  assign setup_rd = PSEL_I & ~PENABLE_I & ~PWRITE_I;

  // Word index; the upper address bits and the byte offset must be clear
  assign idx = PADDR_I[IDX_W+1:2];
  assign upper_zero = (PADDR_I[ADDR_W-1:IDX_W+2] == {(ADDR_W-IDX_W-2){1'b0}});
  assign aligned = (PADDR_I[1:0] == 2'b00);
  assign in_map = upper_zero & aligned;

  // Register select from the word index
  always @* begin
    at_ctrl = 1'b0;
    at_flag = 1'b0;
    at_m0 = 1'b0;
    at_m1 = 1'b0;
    at_m2 = 1'b0;
    at_ist = 1'b0;
    at_imk = 1'b0;
    if (in_map) begin
      case (idx)
        `PCIU_OFS_CTRL: begin
          at_ctrl = 1'b1;
        end
        `PCIU_OFS_FLAG: begin
          at_flag = 1'b1;
        end
        `PCIU_OFS_MASK0: begin
          at_m0 = 1'b1;
        end
        `PCIU_OFS_MASK1: begin
          at_m1 = 1'b1;
        end
        `PCIU_OFS_MASK2: begin
          at_m2 = 1'b1;
        end
        `PCIU_OFS_IRQ_STAT: begin
          at_ist = 1'b1;
        end
        `PCIU_OFS_IRQ_MASK: begin
          at_imk = 1'b1;
        end
        default: begin
          at_ctrl = 1'b0;
        end
      endcase
    end
  end
  assign mapped = at_ctrl | at_flag | at_m0 | at_m1 | at_m2 | at_ist | at_imk;

  // Qualified strobes per register
  assign wr_ctrl = wr & at_ctrl;
  assign wr_flag = wr & at_flag;
  assign wr_m0 = wr & at_m0;
  assign wr_m1 = wr & at_m1;
  assign wr_m2 = wr & at_m2;
  assign wr_imk = wr & at_imk;
  assign rd_ist = rd & at_ist;

  // Zero wait states; unmapped or misaligned accesses answer with an error
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = acc & ~mapped;

  // Per-pin mask, laid out like the source vector
  assign pin_mask = {group2_pin_mask, group1_pin_mask, group0_pin_mask};

  assign grp_hit[0] = |hit[MID_LO-1:0];
  assign grp_hit[1] = |hit[HIGH_LO-1:MID_LO];
  assign grp_hit[2] = |hit[PIN_W-1:HIGH_LO];

  // Clear sources for the flags and the status bits
  assign flag_wr_clear = wr_flag ? PWDATA_I[2:0] : 3'h0;
  assign flag_hw_clear = HANDLER_ENTRY_I;
  assign stat_rd_clear = rd_ist ? 3'h7 : 3'h0;

  // Two-stage synchroniser per pin, then one more stage to compare against
  genvar p;
  generate
    for (p = 0; p < PIN_W; p = p + 1) begin : g_pin
      localparam integer GRP = (p < MID_LO) ? 0 : ((p < HIGH_LO) ? 1 : 2);
      reg sync1;
      reg sync2;
      reg prev;

      always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
          sync1 <= 1'b0;
        end else begin
          sync1 <= pins_in[p];
        end
      end

      // Only the second stage reads the first
      always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
          sync2 <= 1'b0;
        end else begin
          sync2 <= sync1;
        end
      end

      always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
          prev <= 1'b0;
        end else begin
          prev <= sync2;
        end
      end

      assign change[p] = sync2 ^ prev;
      // A cleared mask bit or group enable hides the pin
      assign hit[p] = change[p] & pin_mask[p]
        & group_enable_control[GRP];
    end
  endgenerate

  // Per group: sticky change flag and interrupt status bit
  genvar g;
  generate
    for (g = 0; g < GRP_N; g = g + 1) begin : g_grp
      reg flag;
      reg stat;
      reg next_flag;
      reg next_stat;

      // A new change wins over a clear in the same cycle
      always @* begin
        next_flag = flag;
        if (flag_hw_clear[g] | flag_wr_clear[g]) begin
          next_flag = 1'b0;
        end
        if (grp_hit[g]) begin
          next_flag = 1'b1;
        end
      end

      // Reading the status register clears it, again unless a change arrives
      always @* begin
        next_stat = stat;
        if (stat_rd_clear[g]) begin
          next_stat = 1'b0;
        end
        if (grp_hit[g]) begin
          next_stat = 1'b1;
        end
      end

      always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
          flag <= 1'b0;
        end else begin
          flag <= next_flag;
        end
      end

      always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
          stat <= 1'b0;
        end else begin
          stat <= next_stat;
        end
      end

      assign change_flag_bank[g] = flag;
      assign irq_stat[g] = stat;
    end
  endgenerate

  // Vector request per group: flag, group enable and global bit together
  assign GROUP_VECTOR_REQ_O = change_flag_bank & group_enable_control
    & {GRP_N{CPU_GLOBAL_IRQ_EN_I}};
  assign IRQ_O = |(irq_stat & irq_mask);

  // Group enables, bits 2 to 0
  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      group_enable_control <= `PCIU_RST_GRP;
    end else begin
      if (wr_ctrl) begin
        group_enable_control <= PWDATA_I[2:0];
      end
    end
  end

  // Group 0 mask
  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      group0_pin_mask <= `PCIU_RST_BYTE;
    end else begin
      if (wr_m0) begin
        group0_pin_mask <= PWDATA_I[7:0];
      end
    end
  end

  // Group 1 mask; bit 7 has no storage
  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      group1_pin_mask <= 7'h00;
    end else begin
      if (wr_m1) begin
        group1_pin_mask <= PWDATA_I[6:0];
      end
    end
  end

  // Group 2 mask
  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      group2_pin_mask <= `PCIU_RST_BYTE;
    end else begin
      if (wr_m2) begin
        group2_pin_mask <= PWDATA_I[7:0];
      end
    end
  end

  // Interrupt mask
  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      irq_mask <= `PCIU_RST_GRP;
    end else begin
      if (wr_imk) begin
        irq_mask <= PWDATA_I[2:0];
      end
    end
  end

  // Full-word read images; unused bits read as zero
  assign img_ctrl = {29'h00000000, group_enable_control};
  assign img_flag = {29'h00000000, change_flag_bank};
  assign img_m0 = {24'h000000, group0_pin_mask};
  assign img_m1 = {25'h0000000, group1_pin_mask};
  assign img_m2 = {24'h000000, group2_pin_mask};
  assign img_ist = {29'h00000000, irq_stat};
  assign img_imk = {29'h00000000, irq_mask};

  // Read data for the addressed register
  always @* begin
    next_rdata = 32'h00000000;
    case (idx)
      `PCIU_OFS_CTRL: begin
        next_rdata = img_ctrl;
      end
      `PCIU_OFS_FLAG: begin
        next_rdata = img_flag;
      end
      `PCIU_OFS_MASK0: begin
        next_rdata = img_m0;
      end
      `PCIU_OFS_MASK1: begin
        next_rdata = img_m1;
      end
      `PCIU_OFS_MASK2: begin
        next_rdata = img_m2;
      end
      `PCIU_OFS_IRQ_STAT: begin
        next_rdata = img_ist;
      end
      `PCIU_OFS_IRQ_MASK: begin
        next_rdata = img_imk;
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
    if (!in_map) begin
      next_rdata = 32'h00000000;
    end
  end

  // Read data is loaded in the setup cycle and stands through the access
  always @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      PRDATA_O <= 32'h00000000;
    end else begin
      if (setup_rd) begin
        PRDATA_O <= next_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// >>> pciu_pins.sv
// Far-side pin driver that toggles one source and lets it settle
`timescale 1ns/1ns
`default_nettype none
module pciu_pins(
  input wire logic clk,
  output logic [22:0] pins
);
  initial pins = '0;
  task automatic flip(input int n);
    @(posedge clk);
    pins[n] <= !pins[n];
    repeat (5) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> pciu_chk_properties.sv
// Port checker for the pin change unit
`timescale 1ns/1ns
`default_nettype none
module pciu_chk(
  input wire logic SYS_CLK_I, RST_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O,
  input wire logic CPU_GLOBAL_IRQ_EN_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic [7:0] CHANGE_SOURCES_HIGH_I,
  input wire logic [2:0] HANDLER_ENTRY_I, GROUP_VECTOR_REQ_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  wire rd = PSEL_I && PENABLE_I && !PWRITE_I;
  chk_ready_high: assert property (PREADY_O) else $error("ready low");
  chk_err_phase: assert property (PSLVERR_O |-> PSEL_I && PENABLE_I) else $error("stray error");
  chk_vec_global:
    assert property (GROUP_VECTOR_REQ_O != 0 |-> CPU_GLOBAL_IRQ_EN_I) else $error("vector early");
  chk_reset_clear:
    assert property (disable iff (1'b0) RST_I |=> GROUP_VECTOR_REQ_O == 0 && PRDATA_O == 0)
      else $error("reset state");
  chk_handler_drop:
    assert property ($stable(CHANGE_SOURCES_HIGH_I) [*5] ##0 HANDLER_ENTRY_I[2]
      |=> !GROUP_VECTOR_REQ_O[2]) else $error("flag kept");
  chk_ctrl_read:
    assert property (rd && PADDR_I == 12'h1A0 |-> PRDATA_O[31:3] == 0) else $error("ctrl bits");
  chk_flag_read:
    assert property (rd && PADDR_I == 12'h1A4 |-> PRDATA_O[31:3] == 0) else $error("flag bits");
  chk_mask_read:
    assert property (rd && PADDR_I == 12'h1B0 |-> PRDATA_O[31:7] == 0) else $error("mask bits");
endmodule
bind pciu_top pciu_chk i_chk(.*);
`default_nettype wire

// >>> pin_change_interrupt_unit_bench.sv
// Self-checking bench for the pin change unit
`timescale 1ns/1ns
`default_nettype none
module pin_change_interrupt_unit_bench;
  localparam CTRL = 12'h1A0, FLG = 12'h1A4, M0 = 12'h1AC, M1 = 12'h1B0, M2 = 12'h1B4;
  localparam IST = 12'h1C0, IMK = 12'h1C4;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, gie = 0, err;
  logic [11:0] addr = 0, ra[5] = '{CTRL, FLG, M0, M1, M2};
  logic [31:0] wd = 0, rdat, q;
  logic [2:0] hnd = 0;
  wire [2:0] vec;
  wire rdy, slv, irq;
  wire [22:0] pins;
  int fails = 0, cmp_count = 0;
  always #25 clk = !clk;
  pciu_pins p(.clk(clk), .pins(pins));
  pciu_top i_dut(.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(addr), .PWDATA_I(wd), .PSTRB_I(4'hF), .PRDATA_O(rdat), .PREADY_O(rdy),
    .PSLVERR_O(slv), .CHANGE_SOURCES_LOW_I(pins[7:0]), .CHANGE_SOURCES_MID_I(pins[14:8]),
    .CHANGE_SOURCES_HIGH_I(pins[22:15]), .CPU_GLOBAL_IRQ_EN_I(gie), .HANDLER_ENTRY_I(hnd),
    .GROUP_VECTOR_REQ_O(vec), .IRQ_O(irq));
  task ck(input string n, input [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, addr, wd} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (rdy !== 1);
    q = rdat;
    err = slv;
    {psel, pen} <= 2'b00;
  endtask
  task rc(input [11:0] a, input [31:0] e);
    apb(0, a, 0);
    ck("register", e, q);
  endtask
  task conclude;
    $display("%0d checks, %0d fails", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    conclude;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    foreach (ra[i]) rc(ra[i], 0);
    apb(1, CTRL, 32'hFF);
    rc(CTRL, 32'h7);
    apb(1, M1, 32'hFF);
    rc(M1, 32'h7F);
    apb(1, M0, 32'h1);
    apb(1, M2, 32'h80);
    apb(1, IMK, 32'h7);
    gie <= 1;
    p.flip(1);
    ck("vector", 0, vec);
    p.flip(0);
    ck("vector", 1, vec);
    rc(FLG, 1);
    apb(1, FLG, 0);
    rc(FLG, 1);
    apb(1, FLG, 1);
    rc(FLG, 0);
    p.flip(22);
    ck("vector", 4, vec);
    rc(FLG, 4);
    hnd <= 4;
    @(posedge clk);
    hnd <= 0;
    rc(FLG, 0);
    p.flip(14);
    ck("vector", 2, vec);
    ck("irq", 1, irq);
    gie <= 0;
    repeat (2) @(posedge clk);
    ck("vector", 0, vec);
    rc(IST, 7);
    @(posedge clk);
    ck("irq", 0, irq);
    apb(0, 12'h1FC, 0);
    ck("error", 1, err);
    conclude;
  end
endmodule
`default_nettype wire
